// [src/sarhp_pkg.sv]
// shared constants for the converter control and host read port
package sarhp_pkg;

    // result width and pin nibble layout
    localparam int RES_W      = 12;
    localparam int NIB_W      = 4;
    localparam int TOP_NIB_LO = 8;   // result bits 11..8
    localparam int MID_NIB_LO = 4;   // pins 7..4
    localparam int MSB_IDX    = 11;

    // bit index counter width
    localparam int IDX_W = 4;

    // comparator settling time after a converter clock edge
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int DECIDE_TIME_NS  = 80;
    localparam int DECIDE_CYC_RAW  =
        (DECIDE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DECIDE_CYC      =
        (DECIDE_CYC_RAW < 1) ? 1 : DECIDE_CYC_RAW;
    localparam int SETTLE_W        = 8;

    // reset values
    localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
    localparam logic [RES_W-1:0] APPROX_RST = 12'h000;

    // conversion sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SYNC   = 4'h2,
        ST_WAIT   = 4'h4,
        ST_SETTLE = 4'h8
    } sarhp_state_t;

endpackage

// [src/sarhp_res_if.sv]
// result hand-off between sequencer and output pin stage
`timescale 1ns/1ps
interface sarhp_res_if;
    logic [sarhp_pkg::RES_W-1:0] result;
    logic                        upper_sel;
    logic                        drive;

    modport ctrl (output result, output upper_sel, output drive);
    modport pins (input result, input upper_sel, input drive);
endinterface

// [src/sarhp_outmux.sv]
// output pin multiplexer and three-state enable registers
`timescale 1ns/1ps
module sarhp_outmux #(
    parameter int RES_W = sarhp_pkg::RES_W
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // result side
    sarhp_res_if.pins             res,
    // pin side
    output logic [RES_W-1:0]      output_pins,
    output logic [RES_W-1:0]      output_pins_oe_n
);

    localparam int NW = sarhp_pkg::NIB_W;
    localparam int TL = sarhp_pkg::TOP_NIB_LO;
    localparam int ML = sarhp_pkg::MID_NIB_LO;

    logic [NW-1:0]    top_nib;
    logic [RES_W-1:0] pins_next;

    assign top_nib = res.result[TL +: NW];

    // per nibble: full word, or top nibble, zeros, top nibble again
    genvar n;
    generate
        for (n = 0; n < RES_W / NW; n++) begin : g_nib
            if (n * NW == TL) begin : g_top
                assign pins_next[n*NW +: NW] = top_nib;
            end else if (n * NW == ML) begin : g_mid
                assign pins_next[n*NW +: NW] =
                    res.upper_sel ? '0 : res.result[n*NW +: NW];
            end else begin : g_low
                assign pins_next[n*NW +: NW] =
                    res.upper_sel ? top_nib
                                  : res.result[n*NW +: NW];
            end
        end
    endgenerate

    // pins are registered; enable low means driving
    always_ff @(posedge clk) begin
        if (!resetn) begin
            output_pins      <= '0;
            output_pins_oe_n <= '1;
        end else if (ce) begin
            output_pins      <= pins_next;
            output_pins_oe_n <= {RES_W{~res.drive}};
        end
    end

endmodule

// [src/sarhp_top.sv]
// successive-approximation sequencer with host read port
`timescale 1ns/1ps
// Contract
// - data pins driven only while select and read are both low
// - upper byte select low: pins carry result bits 11 down to 0
// - upper select high: top nibble, four zeros, top nibble again
// - upper select multiplexes the top nibble onto the lower four pins
// - select, read low with upper select low start a conversion
// - read with upper select high only enables the drivers
// - a start clears the approximation register, enables drivers
// - start conditions during a conversion are ignored
// - twelve bits are decided one by one, most significant first
// - top bit decided about 80 ns after second falling clock edge
// - each further bit decided about 80 ns after the next falling clock edge
// - finished approximation value is copied to the output latch
// - busy low through the conversion, high when finished
// - clock output shows the inverse of the converter clock input
// - sequence starts at the first falling converter clock edge
module sarhp_top #(
    parameter int RES_W      = sarhp_pkg::RES_W,
    parameter int DECIDE_CYC = sarhp_pkg::DECIDE_CYC
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // host bus
    input  wire logic             cs_n,
    input  wire logic             rd_n,
    input  wire logic             upper_byte_select,
    output logic [RES_W-1:0]      output_pins,
    output logic [RES_W-1:0]      output_pins_oe_n,
    output logic                  busy_n,
    // converter clock pins
    input  wire logic             conv_clk_in,
    output logic                  conv_clk_out,
    // analog front end
    input  wire logic             comp_keep,
    output logic [RES_W-1:0]      approx_register
);

    localparam logic [sarhp_pkg::IDX_W-1:0] MSB_I =
        sarhp_pkg::IDX_W'(sarhp_pkg::MSB_IDX);
    localparam logic [sarhp_pkg::SETTLE_W-1:0] SETTLE_LOAD =
        sarhp_pkg::SETTLE_W'(DECIDE_CYC - 1);

    sarhp_pkg::sarhp_state_t state_reg, state_next;

    logic [RES_W-1:0]               approx_next;
    logic [RES_W-1:0]               result_reg, result_next;
    logic [sarhp_pkg::IDX_W-1:0]    idx_reg, idx_next;
    logic [sarhp_pkg::SETTLE_W-1:0] settle_reg, settle_next;
    logic                           busy_n_next;
    logic                           cclk_prev_reg;
    logic                           access_prev_reg;

    // host access decode
    wire read_access = ~cs_n & ~rd_n;
    wire start_cond  = read_access & ~upper_byte_select;
    // edge of the access, so a held strobe cannot retrigger
    wire start_evt   = start_cond & ~access_prev_reg;
    wire cclk_fall   = cclk_prev_reg & ~conv_clk_in;
    wire settle_done = (settle_reg == '0);
    wire last_bit    = (idx_reg == '0);

    // one-hot decision mask for the current index and trial bit for the next index
    wire [RES_W-1:0] cur_bit  = RES_W'(1) << idx_reg;
    wire [RES_W-1:0] next_bit = RES_W'(1) << (idx_reg - 1'b1);

    // sequencer next state
    always_comb begin
        state_next  = state_reg;
        approx_next = approx_register;
        result_next = result_reg;
        idx_next    = idx_reg;
        settle_next = settle_reg;
        busy_n_next = busy_n;
        case (state_reg)
            sarhp_pkg::ST_IDLE: begin
                if (start_evt) begin
                    approx_next = sarhp_pkg::APPROX_RST;
                    busy_n_next = 1'b0;
                    state_next  = sarhp_pkg::ST_SYNC;
                end
            end
            sarhp_pkg::ST_SYNC: begin
                // bit sequence begins on first falling edge
                if (cclk_fall) begin
                    approx_next = RES_W'(1) << MSB_I;
                    idx_next    = MSB_I;
                    state_next  = sarhp_pkg::ST_WAIT;
                end
            end
            sarhp_pkg::ST_WAIT: begin
                if (cclk_fall) begin
                    settle_next = SETTLE_LOAD;
                    state_next  = sarhp_pkg::ST_SETTLE;
                end
            end
            sarhp_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    // keep or drop the trial bit, then try the next
                    if (!comp_keep) begin
                        approx_next = approx_register & ~cur_bit;
                    end
                    if (last_bit) begin
                        result_next = comp_keep ? approx_register
                                    : (approx_register & ~cur_bit);
                        busy_n_next = 1'b1;
                        state_next  = sarhp_pkg::ST_IDLE;
                    end else begin
                        approx_next = (comp_keep ? approx_register
                                    : (approx_register & ~cur_bit))
                                    | next_bit;
                        idx_next    = idx_reg - 1'b1;
                        state_next  = sarhp_pkg::ST_WAIT;
                    end
                end else begin
                    settle_next = settle_reg - 1'b1;
                end
            end
            default: begin
                state_next  = sarhp_pkg::ST_IDLE;
                busy_n_next = 1'b1;
            end
        endcase
    end

    // sequencer state; starts while busy fall through ST_IDLE only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= sarhp_pkg::ST_IDLE;
            idx_reg   <= '0;
            settle_reg <= '0;
        end else if (ce) begin
            state_reg  <= state_next;
            idx_reg    <= idx_next;
            settle_reg <= settle_next;
        end
    end

    // approximation register, result latch and busy
    always_ff @(posedge clk) begin
        if (!resetn) begin
            approx_register <= sarhp_pkg::APPROX_RST;
            result_reg      <= sarhp_pkg::RESULT_RST;
            busy_n          <= 1'b1;
        end else if (ce) begin
            approx_register <= approx_next;
            result_reg      <= result_next;
            busy_n          <= busy_n_next;
        end
    end

    // edge history and inverted clock output
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cclk_prev_reg   <= 1'b0;
            access_prev_reg <= 1'b0;
            conv_clk_out    <= 1'b1;
        end else if (ce) begin
            cclk_prev_reg   <= conv_clk_in;
            access_prev_reg <= start_cond;
            conv_clk_out    <= ~conv_clk_in;
        end
    end

    // hand-off to the pin stage; drivers follow the access alone
    sarhp_res_if res_bus ();
    assign res_bus.result    = result_reg;
    assign res_bus.upper_sel = upper_byte_select;
    assign res_bus.drive     = read_access;

    sarhp_outmux #(
        .RES_W (RES_W)
    ) u_outmux (
        .clk              (clk),
        .resetn           (resetn),
        .ce               (ce),
        .res              (res_bus),
        .output_pins      (output_pins),
        .output_pins_oe_n (output_pins_oe_n)
    );

endmodule

// [testbench/sarhp_top_properties.sv]
// concurrent checks on the converter host read port
`timescale 1ns/1ps
module sarhp_top_properties #(
    parameter int RES_W      = 12,
    parameter int DECIDE_CYC = 20
) (
    // clocking and host bus
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             ce,
    input wire logic             cs_n,
    input wire logic             rd_n,
    input wire logic             upper_byte_select,
    // converter side
    input wire logic [RES_W-1:0] output_pins,
    input wire logic [RES_W-1:0] output_pins_oe_n,
    input wire logic             busy_n,
    input wire logic             conv_clk_in,
    input wire logic             conv_clk_out,
    input wire logic             comp_keep,
    input wire logic [RES_W-1:0] approx_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire acc = ce && !cs_n && !rd_n;
    // fresh access edge, lower form, converter idle
    sequence s_start;
        acc && !upper_byte_select && busy_n && !$past(acc);
    endsequence
    // busy low for a while, then released within a bound
    sequence s_conv;
        (!busy_n)[*8] ##[1:1000] busy_n;
    endsequence
    AST_OE_OFF: assert property (ce && !acc |=> &output_pins_oe_n)
        else $error("drivers on without access");
    AST_OE_ON: assert property (acc |=> output_pins_oe_n == '0)
        else $error("drivers off during access");
    AST_UPPER: assert property (
        acc && upper_byte_select |=> output_pins[7:4] == 4'h0
        && output_pins[3:0] == output_pins[11:8])
        else $error("upper byte form wrong");
    AST_NO_UP_START: assert property (
        acc && upper_byte_select && busy_n && !$past(acc) |=> busy_n)
        else $error("upper read started a conversion");
    AST_START: assert property (
        s_start |=> !busy_n && approx_register == '0)
        else $error("start not taken");
    AST_CONV: assert property ($fell(busy_n) |-> s_conv)
        else $error("conversion length wrong");
    AST_CLKOUT: assert property (
        ce |=> conv_clk_out == !$past(conv_clk_in))
        else $error("clock output not inverted");
    AST_IDLE_HOLD: assert property (
        busy_n && $past(busy_n) |-> $stable(approx_register))
        else $error("register moved while idle");
    // once the trial bits run, a restart would clear the register early
    AST_SEQ_HOLD: assert property (
        !busy_n && approx_register != '0
        |=> busy_n || approx_register != '0)
        else $error("conversion restarted while busy");
endmodule

bind sarhp_top sarhp_top_properties #(
    .RES_W(RES_W), .DECIDE_CYC(DECIDE_CYC)) u_props (
    .clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .output_pins(output_pins),
    .output_pins_oe_n(output_pins_oe_n), .busy_n(busy_n),
    .conv_clk_in(conv_clk_in), .conv_clk_out(conv_clk_out),
    .comp_keep(comp_keep), .approx_register(approx_register));

// [testbench/sarhp_front_model.sv]
// comparator and converter clock source facing the converter
`timescale 1ns/1ps
module sarhp_front_model #(
    parameter int HALF = 8
) (
    // timing
    input  wire logic        clk,
    // analog side
    input  wire logic [11:0] analog_input,
    input  wire logic [11:0] approx_register,
    output logic             comp_keep,
    output logic             conv_clk_in
);
    int   cnt = 0;
    logic ck  = 1'b1;
    assign conv_clk_in = ck;
    // free-running, like an external oscillator
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            ck <= !ck;
        end
    end
    // ideal comparator: keep the trial bit while the code fits
    assign comp_keep = approx_register <= analog_input;
endmodule

// [testbench/test_sar_adc_host_read_port.sv]
// self-checking bench for the converter host read port
`timescale 1ns/1ps
module test_sar_adc_host_read_port;
    logic        clk = 1'b0, resetn = 1'b0, ubs = 1'b0;
    logic        cs_n = 1'b1, rd_n = 1'b1, oe_prev = 1'b1;
    logic        ce = 1'b1;
    logic        busy_n, ck_in, ck_out, keep;
    logic [11:0] vin = 12'h000, last = 12'h000, pins, oe_n, approx;
    logic [11:0] exp_q[$];
    integer      seed = 32'he9095b89;
    int          miscompares = 0, n_compared = 0, cycles = 0;

    initial begin
        forever #2 clk = ~clk;
    end
    // short decide time keeps conversions brief
    sarhp_top #(.DECIDE_CYC(4)) DUT (
        .clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .rd_n(rd_n),
        .upper_byte_select(ubs), .output_pins(pins),
        .output_pins_oe_n(oe_n), .busy_n(busy_n), .conv_clk_in(ck_in),
        .conv_clk_out(ck_out), .comp_keep(keep), .approx_register(approx));
    sarhp_front_model #(.HALF(8)) u_front (
        .clk(clk), .analog_input(vin), .approx_register(approx),
        .comp_keep(keep), .conv_clk_in(ck_in));

    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        check("pending_notes", 12'(exp_q.size()), 12'h000);
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one read access; lower form while idle also starts a conversion
    task automatic read(input logic up, input logic [11:0] exp);
        exp_q.push_back(exp);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        ubs <= up;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
        ubs <= 1'b0;
        @(posedge clk);
    endtask

    // bounded wait so a stuck busy cannot hang the run
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_n !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n == 2000) begin
            miscompares++;
            end_sim();
        end
    endtask

    // drivers coming on mark a result; compare with the oldest note
    always @(negedge clk) begin
        if (oe_prev && oe_n[0] === 1'b0) begin
            check("output_pins", pins, exp_q.pop_front());
        end
        oe_prev <= oe_n[0];
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        logic [11:0] v;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // corner codes first, then random ones
        for (int i = 0; i < 10; i++) begin
            v = i == 0 ? 12'h000 : i == 1 ? 12'hfff : i == 2 ? 12'h800
                : i == 3 ? 12'h7ff : 12'($random(seed));
            vin <= v;
            @(posedge ck_in);
            @(posedge clk);
            read(1'b0, last);
            // freeze mid-conversion; the result must still come out right
            repeat (8) @(posedge clk);
            ce <= 1'b0;
            repeat (5) @(posedge clk);
            ce <= 1'b1;
            repeat (7) @(posedge clk);
            read(1'b0, last);
            wait_idle();
            last = v;
            read(1'b1, {v[11:8], 4'h0, v[11:8]});
            read(1'b1, {v[11:8], 4'h0, v[11:8]});
        end
        read(1'b0, last);
        wait_idle();
        end_sim();
    end
endmodule
